// *** dv/pps_plant.sv ***
`timescale 1ns/10ps
module pps_plant (
  input wire logic hclk,
  input wire logic hresetn,
  input wire pps_pkg::pps_act_t act,
  input wire logic jk_ok,
  input wire logic ld_ok,
  output logic jockey_flow_sw,
  output logic lead_flow_sw
);
  logic [2:0] jk_ff;
  logic [2:0] ld_ff;
  // flow builds a few cycles after start; a failed pump never closes its switch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jk_ff <= 3'h0;
      ld_ff <= 3'h0;
    end else begin
      jk_ff <= (act.jockey_run && jk_ok) ? jk_ff + {2'h0, jk_ff != 3'h7} : 3'h0;
      ld_ff <= (act.lead_run && ld_ok) ? ld_ff + {2'h0, ld_ff != 3'h7} : 3'h0;
    end
  end
  assign jockey_flow_sw = (jk_ff == 3'h7);
  assign lead_flow_sw = (ld_ff == 3'h7);
endmodule

// *** dv/pps_sequencer_sva.sv ***
`timescale 1ns/10ps
module pps_sequencer_sva #(
  parameter int TICK_CYCLES = 10,
  parameter int PROVE_TICKS = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic jockey_flow_sw,
  input wire logic lead_flow_sw,
  input wire pps_pkg::pps_sol_t sol,
  input wire pps_pkg::pps_act_t act,
  input wire pps_pkg::pps_alm_t alm
);
  // margin covers tick phase and the input synchroniser
  localparam int LIM = PROVE_TICKS * TICK_CYCLES + 2 * TICK_CYCLES + 4;
  int starve_ff;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // saturating count of jockey run cycles without flow, so it never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      starve_ff <= 0;
    end else if (!act.jockey_run || jockey_flow_sw) begin
      starve_ff <= 0;
    end else if (starve_ff < LIM) begin
      starve_ff <= starve_ff + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_pump_on;
    act.jockey_run || act.lead_run;
  endsequence
  sequence s_jk_loss;
    (act.jockey_run && jockey_flow_sw) [*8] ##1 (act.jockey_run && !jockey_flow_sw);
  endsequence
  sequence s_ld_loss;
    (act.lead_run && lead_flow_sw) [*8] ##1 (act.lead_run && !lead_flow_sw);
  endsequence
  sequence s_iso_close;
    $fell(act.iso_open) && alm.ready;
  endsequence
  property p_ready_loops;
    $rose(alm.ready) |-> ##[0:2] (act.lva_close && act.lvb_close && act.lvc_open);
  endproperty
  property p_prep_sol;
    s_pump_on |-> (!sol.bp_a && sol.bp_b && !sol.df_a && !sol.df_b);
  endproperty
  property p_prep_pcb;
    s_pump_on |-> !sol.pc_b;
  endproperty
  property p_pump_iso;
    s_pump_on |-> act.iso_open;
  endproperty
  property p_run_high;
    s_iso_close |-> (!act.jockey_run && !act.lead_run && !sol.bp_a && !sol.bp_b);
  endproperty
  property p_relief;
    s_iso_close ##0 $past(sol.bp_b) |-> (!sol.pc_a && !sol.pc_b);
  endproperty
  property p_low;
    ($rose(act.iso_open) && !act.jockey_run && !act.lead_run) |-> (sol.pc_a && sol.pc_b);
  endproperty
  property p_jk_timeout;
    (starve_ff == LIM) |-> alm.jockey_alarm;
  endproperty
  property p_jk_loss;
    s_jk_loss |-> ##[0:8] alm.jockey_alarm;
  endproperty
  property p_ld_loss;
    s_ld_loss |-> ##[0:8] alm.lead_alarm;
  endproperty
  property p_lead_backup;
    ($rose(alm.jockey_alarm) && sol.bp_b) |-> ##[0:4] act.lead_run;
  endproperty
  a_ready_loops: assert property (p_ready_loops)
    else $error("loop valves not set with ready");
  a_prep_sol: assert property (p_prep_sol)
    else $error("solenoids wrong while pump runs");
  a_prep_pcb: assert property (p_prep_pcb)
    else $error("pressure control b on while pump runs");
  a_pump_iso: assert property (p_pump_iso)
    else $error("isolation valve closed while pump runs");
  a_run_high: assert property (p_run_high)
    else $error("pump or backpressure left on at isolation close");
  a_relief: assert property (p_relief)
    else $error("pressure control not at relief after run high");
  a_low: assert property (p_low)
    else $error("pressure control not at low setpoint");
  a_jk_timeout: assert property (p_jk_timeout)
    else $error("jockey proving timeout without alarm");
  a_jk_loss: assert property (p_jk_loss)
    else $error("jockey flow loss without alarm");
  a_ld_loss: assert property (p_ld_loss)
    else $error("lead flow loss without alarm");
  a_lead_backup: assert property (p_lead_backup)
    else $error("lead pump not started after jockey failure");
endmodule

bind pps_sequencer pps_sequencer_sva #(
  .TICK_CYCLES(TICK_CYCLES),
  .PROVE_TICKS(PROVE_TICKS)
) u_sva (
  .hclk(hclk),
  .hresetn(hresetn),
  .jockey_flow_sw(jockey_flow_sw),
  .lead_flow_sw(lead_flow_sw),
  .sol(sol),
  .act(act),
  .alm(alm)
);

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
  localparam int TK = 10;
  localparam int PT = 5;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic jockey_flow_sw;
  logic lead_flow_sw;
  logic [7:0] fuel_pump_running = 8'h0;
  logic [11:0] valve_limits = 12'h0;
  logic jk_ok = 1'b0;
  logic ld_ok = 1'b1;
  logic byp = 1'b0;
  logic [31:0] q;
  int error_cnt = 0;
  int num_checks = 0;
  pps_pkg::pps_sol_t sol;
  pps_pkg::pps_act_t act;
  pps_pkg::pps_alm_t alm;
  always #4 hclk = ~hclk;
  pps_sequencer #(.TICK_CYCLES(TK), .PROVE_TICKS(PT), .BYPASS_SECONDS(3), .SEC_TICKS(2)) dut (
    .hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .jockey_flow_sw, .lead_flow_sw,
    .fuel_pump_running, .valve_limits, .sol, .act, .alm);
  pps_plant plant (.hclk, .hresetn, .act, .jk_ok, .ld_ok, .jockey_flow_sw, .lead_flow_sw);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("reg", e, q);
    chk("resp", 32'h0, {31'h0, hresp});
  endtask
  task automatic step(input logic [1:0] m, input logic [2:0] c, input logic s);
    bus(1'b1, pps_pkg::REG_CTRL, {22'h0, s, byp, c != pps_pkg::CMD_NONE, c, 2'h0, m});
    settle(4);
  endtask
  task automatic co(input logic [5:0] es, input logic [5:0] ea, input logic [4:0] el);
    chk("sol", {26'h0, es}, {26'h0, sol});
    chk("act", {26'h0, ea}, {26'h0, act});
    chk("alm", {27'h0, el}, {27'h0, alm});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    settle(5);
    hresetn <= 1'b1;
    settle(1);
    co(6'h0, 6'h0, 5'h0);
    rd(pps_pkg::REG_OUTS, 32'h0);
    rd(8'h18, 32'h0);
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_NONE, 1'b0);
    chk("idle", 32'h1c, {26'h0, act});
    chk("ready", 32'h1, {31'h0, alm.ready});
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_PREP_HI1, 1'b0);
    co(6'b011000, 6'b111110, 5'b00001);
    settle(3 * TK);
    chk("jk early", 32'h0, {31'h0, alm.jockey_alarm});
    settle((PT + 2) * TK);
    chk("jk late", 32'h1, {31'h0, alm.jockey_alarm});
    chk("lead", 32'h1, {31'h0, act.lead_run});
    settle((PT + 2) * TK);
    chk("ld ok", 32'h0, {31'h0, alm.lead_alarm});
    ld_ok <= 1'b0;
    settle(8);
    chk("ld loss", 32'h1, {31'h0, alm.lead_alarm});
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_RUN_HI1, 1'b0);
    co(6'b000000, 6'b011100, 5'b11001);
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_PREP_LO, 1'b0);
    co(6'b001100, 6'b111100, 5'b11001);
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_RUN_LO, 1'b0);
    co(6'b001100, 6'b011100, 5'b11001);
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_RUN_HI2, 1'b0);
    co(6'b001100, 6'b011100, 5'b11001);
    ld_ok <= 1'b1;
    jk_ok <= 1'b1;
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_PREP_HI2, 1'b0);
    chk("sol", 32'h10, {26'h0, sol});
    chk("act", 32'h1f, {27'h0, act[5:1]});
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_RUN_HI2, 1'b0);
    co(6'b000000, 6'b011100, 5'b11001);
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_DONE, 1'b0);
    settle(20);
    co(6'b000000, 6'b011100, 5'b11001);
    step(pps_pkg::MODE_OFF, pps_pkg::CMD_NONE, 1'b0);
    step(pps_pkg::MODE_TEST, pps_pkg::CMD_PREP_HI1, 1'b0);
    settle((PT + 2) * TK);
    chk("jk proved", 32'h0, {30'h0, alm.jockey_alarm, act.lead_run});
    jk_ok <= 1'b0;
    settle(8);
    chk("jk loss", 32'h3, {30'h0, alm.jockey_alarm, act.lead_run});
    jk_ok <= 1'b1;
    step(pps_pkg::MODE_OFF, pps_pkg::CMD_NONE, 1'b0);
    fuel_pump_running <= 8'h01;
    settle(6);
    chk("off on", 32'hc, {28'h0, sol.bp_a, sol.pc_a, sol.df_a, sol.df_b});
    chk("no auto", 32'h0, {30'h0, act.jockey_run, act.lead_run});
    fuel_pump_running <= 8'h03;
    settle(2);
    fuel_pump_running <= 8'h02;
    settle(6);
    chk("off one", 32'hc, {28'h0, sol.bp_a, sol.pc_a, sol.df_a, sol.df_b});
    fuel_pump_running <= 8'h00;
    settle(6);
    chk("off last", 32'h2, {28'h0, sol.bp_a, sol.pc_a, sol.df_a, sol.df_b});
    step(pps_pkg::MODE_AUTO, pps_pkg::CMD_NONE, 1'b0);
    valve_limits <= 12'h5a5;
    settle(6);
    chk("mani", 32'h3, {30'h0, alm.manifold_alarm, alm.manifold_audible});
    rd(pps_pkg::REG_POS, 32'h5a5);
    step(pps_pkg::MODE_AUTO, pps_pkg::CMD_NONE, 1'b1);
    chk("silenced", 32'h2, {30'h0, alm.manifold_alarm, alm.manifold_audible});
    byp = 1'b1;
    step(pps_pkg::MODE_AUTO, pps_pkg::CMD_NONE, 1'b0);
    chk("bypass", 32'h0, {31'h0, alm.manifold_alarm});
    settle(3 * 2 * TK + 10);
    chk("expired", 32'h1, {31'h0, alm.manifold_alarm});
    bus(1'b0, pps_pkg::REG_STAT, 32'h0);
    chk("stat exp", 32'h1, {31'h0, q[12]});
    byp = 1'b0;
    step(pps_pkg::MODE_AUTO, pps_pkg::CMD_NONE, 1'b0);
    byp = 1'b1;
    step(pps_pkg::MODE_AUTO, pps_pkg::CMD_NONE, 1'b0);
    chk("rebypass", 32'h0, {31'h0, alm.manifold_alarm});
    byp = 1'b0;
    step(pps_pkg::MODE_AUTO, pps_pkg::CMD_NONE, 1'b0);
    chk("enable", 32'h1, {31'h0, alm.manifold_alarm});
    bus(1'b1, pps_pkg::REG_VIDX, 32'h3);
    bus(1'b1, pps_pkg::REG_VTAB, 32'h5a5);
    settle(6);
    chk("conform", 32'h0, {31'h0, alm.manifold_alarm});
    rd(pps_pkg::REG_VIDX, 32'h3);
    rd(pps_pkg::REG_VTAB, 32'h5a5);
    step(pps_pkg::MODE_OTHER, pps_pkg::CMD_NONE, 1'b0);
    valve_limits <= 12'h0f0;
    settle(6);
    chk("other", 32'h0, {31'h0, alm.manifold_alarm});
    tally_and_finish;
  end
endmodule

// *** hdl/pps_pkg.sv ***
package pps_pkg;

  // mode selector encoding
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_TEST = 2'h2;
  localparam logic [1:0] MODE_OTHER = 2'h3;

  // test step command encoding from the external panel
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_PREP_HI1 = 3'h1;
  localparam logic [2:0] CMD_RUN_HI1 = 3'h2;
  localparam logic [2:0] CMD_PREP_LO = 3'h3;
  localparam logic [2:0] CMD_RUN_LO = 3'h4;
  localparam logic [2:0] CMD_PREP_HI2 = 3'h5;
  localparam logic [2:0] CMD_RUN_HI2 = 3'h6;
  localparam logic [2:0] CMD_DONE = 3'h7;

  // timing
  localparam int CLK_HZ = 125000000;
  localparam int PROVE_S = 15;
  localparam int BYPASS_H = 12;
  localparam int BYPASS_S = BYPASS_H * 3600;
  // one tick per millisecond keeps all timers small
  localparam int TICK_CYC = CLK_HZ / 1000;
  localparam int PROVE_TICKS = PROVE_S * 1000;
  localparam int BYPASS_SEC_TICKS = 1000;

  // register access via AHB-Lite, word offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_OUTS = 8'h08;
  localparam logic [7:0] REG_VTAB = 8'h0c;
  localparam logic [7:0] REG_VIDX = 8'h10;
  localparam logic [7:0] REG_POS = 8'h14;

  // ctrl field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CMD_LSB = 4;
  localparam int CTRL_CMD_STB = 7;
  localparam int CTRL_BYP = 8;
  localparam int CTRL_SIL = 9;

  localparam int VTAB_DEPTH = 8;
  localparam int VLV_N = 6;

  typedef struct packed {
    logic bp_a;
    logic bp_b;
    logic pc_a;
    logic pc_b;
    logic df_a;
    logic df_b;
  } pps_sol_t;

  typedef struct packed {
    logic iso_open;
    logic lva_close;
    logic lvb_close;
    logic lvc_open;
    logic jockey_run;
    logic lead_run;
  } pps_act_t;

  typedef struct packed {
    logic jockey_alarm;
    logic lead_alarm;
    logic manifold_alarm;
    logic manifold_audible;
    logic ready;
  } pps_alm_t;

endpackage

// *** hdl/pps_sequencer.sv ***
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - entering test mode: ready to panel, close loop valves a,b, open c.
// - both prepare-high steps: backpressure A off, B on.
// - both prepare-high steps: defuel/flush solenoids both off.
// - prepare-high1: pressure control A on B off; prepare-high2: both off.
// - entering prepare-high step starts the jockey pump.
// - jockey started: 15 s prove timer, alarm if flow not proved in time.
// - jockey flow switch opening after proof raises its alarm.
// - jockey fails to prove in prepare-high: start lead fueling pump.
// - lead pump gets same 15 s proving and flow-loss alarm.
// - prepare-high opens isolation valve, pump runs until run-high.
// - run-high closes isolation, stops pumps, backpressure solenoids off.
// - run-high drives both pressure control solenoids off.
// - prepare-low opens isolation, pressure control both on, hold.
// - run-low closes isolation and holds until prepare-high2.
// - after done, outputs hold until mode selector changes.
// - off mode inhibits automatic pump starts; solenoids stay active.
// - off mode first fueling pump on: bp A on, pc A on, df both off.
// - off mode last pump off: bp A, pc A off; df A on, df B off.
// - monitor open and closed limits of six supervised valves.
// - auto/test nonconforming positions raise latched critical alarm; the alarm is not latched here and clears once positions conform.
// - bypass switch suppresses alarm; cancelled after 12 h, reset on enable.
module pps_sequencer #(
  parameter int TICK_CYCLES = pps_pkg::TICK_CYC,
  parameter int PROVE_TICKS = pps_pkg::PROVE_TICKS,
  parameter int BYPASS_SECONDS = pps_pkg::BYPASS_S,
  parameter int SEC_TICKS = pps_pkg::BYPASS_SEC_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic jockey_flow_sw,
  input wire logic lead_flow_sw,
  input wire logic [pps_pkg::VTAB_DEPTH-1:0] fuel_pump_running,
  input wire logic [2*pps_pkg::VLV_N-1:0] valve_limits,
  output pps_pkg::pps_sol_t sol,
  output pps_pkg::pps_act_t act,
  output pps_pkg::pps_alm_t alm
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_PREP_HI1 = 8'h02,
    ST_RUN_HI1 = 8'h04,
    ST_PREP_LO = 8'h08,
    ST_RUN_LO = 8'h10,
    ST_PREP_HI2 = 8'h20,
    ST_RUN_HI2 = 8'h40,
    ST_DONE = 8'h80
  } pps_st_t;

  pps_st_t state_ff, nxt_state;
  logic [1:0] mode_ff, prev_mode_ff;
  logic [2:0] cmd_ff;
  logic cmd_stb_ff;
  logic byp_sw_ff, sil_ff;
  logic [1:0] jfs_sync_ff, lfs_sync_ff;
  logic [pps_pkg::VTAB_DEPTH-1:0] run_s1_ff, run_s2_ff;
  logic [2*pps_pkg::VLV_N-1:0] lim_s1_ff, lim_s2_ff;
  logic [2*pps_pkg::VLV_N-1:0] vtab_ff [pps_pkg::VTAB_DEPTH];
  logic [2:0] vidx_ff;
  logic [31:0] tick_cnt_ff;
  logic tick;
  logic [31:0] jt_ff, lt_ff;
  logic j_proved_ff, l_proved_ff;
  logic [31:0] sec_cnt_ff, byp_sec_ff;
  logic byp_expired_ff;
  logic any_run_ff;
  logic ph_wr_ff;
  logic [7:0] ph_addr_ff;
  logic manifold_ok;
  logic in_test;
  logic entering_prep;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign in_test = (mode_ff == pps_pkg::MODE_TEST);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for field inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jfs_sync_ff <= 2'h0;
      lfs_sync_ff <= 2'h0;
      run_s1_ff <= '0;
      run_s2_ff <= '0;
      lim_s1_ff <= '0;
      lim_s2_ff <= '0;
    end else if (clk_en) begin
      jfs_sync_ff <= {jfs_sync_ff[0], jockey_flow_sw};
      lfs_sync_ff <= {lfs_sync_ff[0], lead_flow_sw};
      run_s1_ff <= fuel_pump_running;
      run_s2_ff <= run_s1_ff;
      lim_s1_ff <= valve_limits;
      lim_s2_ff <= lim_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_ff <= 1'b0;
      ph_addr_ff <= 8'h00;
    end else if (clk_en && hready) begin
      ph_wr_ff <= hsel && htrans[1] && hwrite && (hsize == 3'h2);
      ph_addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= pps_pkg::MODE_OFF;
      cmd_ff <= pps_pkg::CMD_NONE;
      cmd_stb_ff <= 1'b0;
      byp_sw_ff <= 1'b0;
      sil_ff <= 1'b0;
      vidx_ff <= 3'h0;
    end else if (clk_en) begin
      cmd_stb_ff <= 1'b0;
      if (ph_wr_ff && ph_addr_ff == pps_pkg::REG_CTRL) begin
        mode_ff <= hwdata[pps_pkg::CTRL_MODE_LSB +: 2];
        cmd_ff <= hwdata[pps_pkg::CTRL_CMD_LSB +: 3];
        cmd_stb_ff <= hwdata[pps_pkg::CTRL_CMD_STB];
        byp_sw_ff <= hwdata[pps_pkg::CTRL_BYP];
        sil_ff <= hwdata[pps_pkg::CTRL_SIL];
      end
      if (ph_wr_ff && ph_addr_ff == pps_pkg::REG_VIDX)
        vidx_ff <= hwdata[2:0];
      if (manifold_ok)
        sil_ff <= 1'b0;
    end
  end

  // position table, one row per allowed set of limit states
  genvar gi;
  generate
    for (gi = 0; gi < pps_pkg::VTAB_DEPTH; gi++) begin : g_vtab
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          vtab_ff[gi] <= '0;
        else if (clk_en && ph_wr_ff && ph_addr_ff == pps_pkg::REG_VTAB && vidx_ff == gi)
          vtab_ff[gi] <= hwdata[2*pps_pkg::VLV_N-1:0];
      end
    end
  endgenerate

  always_comb begin
    manifold_ok = 1'b0;
    for (int i = 0; i < pps_pkg::VTAB_DEPTH; i++)
      if (vtab_ff[i] == lim_s2_ff)
        manifold_ok = 1'b1;
  end

  always_comb begin
    hrdata = 32'h0;
    case (ph_addr_ff)
      pps_pkg::REG_CTRL: hrdata = {22'h0, sil_ff, byp_sw_ff, 1'b0, cmd_ff, 2'h0, mode_ff};
      pps_pkg::REG_STAT: hrdata = {19'h0, byp_expired_ff, manifold_ok, state_ff,
                                   j_proved_ff, l_proved_ff, 1'b0};
      pps_pkg::REG_OUTS: hrdata = {15'h0, alm, act, sol};
      pps_pkg::REG_VTAB: hrdata = {20'h0, vtab_ff[vidx_ff]};
      pps_pkg::REG_VIDX: hrdata = {29'h0, vidx_ff};
      pps_pkg::REG_POS: hrdata = {20'h0, lim_s2_ff};
      default: hrdata = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared millisecond time base
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_ff <= 32'h0;
    end else if (clk_en) begin
      if (tick_cnt_ff == 32'(TICK_CYCLES - 1))
        tick_cnt_ff <= 32'h0;
      else
        tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end
  assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  always_comb begin
    nxt_state = state_ff;
    if (!in_test) begin
      nxt_state = ST_IDLE;
    end else if (cmd_stb_ff) begin
      case (state_ff)
        ST_IDLE: if (cmd_ff == pps_pkg::CMD_PREP_HI1) nxt_state = ST_PREP_HI1;
        ST_PREP_HI1: if (cmd_ff == pps_pkg::CMD_RUN_HI1) nxt_state = ST_RUN_HI1;
        ST_RUN_HI1: if (cmd_ff == pps_pkg::CMD_PREP_LO) nxt_state = ST_PREP_LO;
        ST_PREP_LO: if (cmd_ff == pps_pkg::CMD_RUN_LO) nxt_state = ST_RUN_LO;
        ST_RUN_LO: if (cmd_ff == pps_pkg::CMD_PREP_HI2) nxt_state = ST_PREP_HI2;
        ST_PREP_HI2: if (cmd_ff == pps_pkg::CMD_RUN_HI2) nxt_state = ST_RUN_HI2;
        ST_RUN_HI2: if (cmd_ff == pps_pkg::CMD_DONE) nxt_state = ST_DONE;
        ST_DONE: nxt_state = ST_DONE;
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      state_ff <= ST_IDLE;
    else if (clk_en)
      state_ff <= nxt_state;
  end

  assign entering_prep = (nxt_state != state_ff) &&
                         (nxt_state == ST_PREP_HI1 || nxt_state == ST_PREP_HI2);

  ////////////////////////////////////////////////////////////////////////////
  // pump commands and flow proving; auto starts only exist in test mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act.jockey_run <= 1'b0;
      act.lead_run <= 1'b0;
    end else if (clk_en) begin
      if (!in_test) begin
        act.jockey_run <= 1'b0;
        act.lead_run <= 1'b0;
      end else if (entering_prep) begin
        act.jockey_run <= 1'b1;
      end else if (nxt_state == ST_RUN_HI1 || nxt_state == ST_RUN_HI2) begin
        act.jockey_run <= 1'b0;
        act.lead_run <= 1'b0;
      end else if (act.jockey_run && !act.lead_run && alm.jockey_alarm &&
                   (state_ff == ST_PREP_HI1 || state_ff == ST_PREP_HI2)) begin
        act.lead_run <= 1'b1;
      end
    end
  end

  // jockey proving; the alarm is sticky until a mode change, which clears it only if no set condition holds in that cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jt_ff <= 32'h0;
      j_proved_ff <= 1'b0;
      alm.jockey_alarm <= 1'b0;
    end else if (clk_en) begin
      if (!act.jockey_run) begin
        jt_ff <= 32'h0;
        j_proved_ff <= 1'b0;
      end else if (!j_proved_ff && jfs_sync_ff[1]) begin
        j_proved_ff <= 1'b1;
      end else if (!j_proved_ff && tick && jt_ff != 32'(PROVE_TICKS)) begin
        jt_ff <= jt_ff + 32'h1;
      end
      if (act.jockey_run && !j_proved_ff && jt_ff == 32'(PROVE_TICKS))
        alm.jockey_alarm <= 1'b1;
      else if (act.jockey_run && j_proved_ff && !jfs_sync_ff[1])
        alm.jockey_alarm <= 1'b1;
      else if (mode_ff != prev_mode_ff)
        alm.jockey_alarm <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lt_ff <= 32'h0;
      l_proved_ff <= 1'b0;
      alm.lead_alarm <= 1'b0;
    end else if (clk_en) begin
      if (!act.lead_run) begin
        lt_ff <= 32'h0;
        l_proved_ff <= 1'b0;
      end else if (!l_proved_ff && lfs_sync_ff[1]) begin
        l_proved_ff <= 1'b1;
      end else if (!l_proved_ff && tick && lt_ff != 32'(PROVE_TICKS)) begin
        lt_ff <= lt_ff + 32'h1;
      end
      if (act.lead_run && !l_proved_ff && lt_ff == 32'(PROVE_TICKS))
        alm.lead_alarm <= 1'b1;
      else if (act.lead_run && l_proved_ff && !lfs_sync_ff[1])
        alm.lead_alarm <= 1'b1;
      else if (mode_ff != prev_mode_ff)
        alm.lead_alarm <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // valve and solenoid outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_mode_ff <= pps_pkg::MODE_OFF;
      any_run_ff <= 1'b0;
      sol <= '0;
      act.iso_open <= 1'b0;
      act.lva_close <= 1'b0;
      act.lvb_close <= 1'b0;
      act.lvc_open <= 1'b0;
      alm.ready <= 1'b0;
    end else if (clk_en) begin
      prev_mode_ff <= mode_ff;
      any_run_ff <= |run_s2_ff;
      alm.ready <= in_test;
      if (in_test && prev_mode_ff != pps_pkg::MODE_TEST) begin
        act.lva_close <= 1'b1;
        act.lvb_close <= 1'b1;
        act.lvc_open <= 1'b1;
      end else if (!in_test) begin
        act.lva_close <= 1'b0;
        act.lvb_close <= 1'b0;
        act.lvc_open <= 1'b0;
      end
      if (in_test && nxt_state != state_ff) begin
        case (nxt_state)
          ST_PREP_HI1: begin
            sol.bp_a <= 1'b0;
            sol.bp_b <= 1'b1;
            sol.df_a <= 1'b0;
            sol.df_b <= 1'b0;
            sol.pc_a <= 1'b1;
            sol.pc_b <= 1'b0;
            act.iso_open <= 1'b1;
          end
          ST_PREP_HI2: begin
            sol.bp_a <= 1'b0;
            sol.bp_b <= 1'b1;
            sol.df_a <= 1'b0;
            sol.df_b <= 1'b0;
            sol.pc_a <= 1'b0;
            sol.pc_b <= 1'b0;
            act.iso_open <= 1'b1;
          end
          ST_RUN_HI1, ST_RUN_HI2: begin
            act.iso_open <= 1'b0;
            sol.bp_a <= 1'b0;
            sol.bp_b <= 1'b0;
            sol.pc_a <= 1'b0;
            sol.pc_b <= 1'b0;
          end
          ST_PREP_LO: begin
            act.iso_open <= 1'b1;
            sol.pc_a <= 1'b1;
            sol.pc_b <= 1'b1;
          end
          ST_RUN_LO: act.iso_open <= 1'b0;
          default: act.iso_open <= act.iso_open;
        endcase
      end else if (mode_ff == pps_pkg::MODE_OFF) begin
        act.iso_open <= 1'b0;
        if (|run_s2_ff && !any_run_ff) begin
          sol.bp_a <= 1'b1;
          sol.pc_a <= 1'b1;
          sol.df_a <= 1'b0;
          sol.df_b <= 1'b0;
        end else if (!(|run_s2_ff) && any_run_ff) begin
          sol.bp_a <= 1'b0;
          sol.pc_a <= 1'b0;
          sol.df_a <= 1'b1;
          sol.df_b <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // manifold supervision and 12 h bypass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt_ff <= 32'h0;
      byp_sec_ff <= 32'h0;
      byp_expired_ff <= 1'b0;
    end else if (clk_en) begin
      if (!byp_sw_ff) begin
        sec_cnt_ff <= 32'h0;
        byp_sec_ff <= 32'h0;
        byp_expired_ff <= 1'b0;
      end else if (!byp_expired_ff && tick) begin
        if (sec_cnt_ff == 32'(SEC_TICKS - 1)) begin
          sec_cnt_ff <= 32'h0;
          byp_sec_ff <= byp_sec_ff + 32'h1;
          if (byp_sec_ff == 32'(BYPASS_SECONDS - 1))
            byp_expired_ff <= 1'b1;
        end else begin
          sec_cnt_ff <= sec_cnt_ff + 32'h1;
        end
      end
    end
  end

  // alarm holds while positions stay wrong; bypass masks it until expiry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alm.manifold_alarm <= 1'b0;
      alm.manifold_audible <= 1'b0;
    end else if (clk_en) begin
      alm.manifold_alarm <= !manifold_ok &&
                            (mode_ff == pps_pkg::MODE_AUTO || in_test) &&
                            !(byp_sw_ff && !byp_expired_ff);
      alm.manifold_audible <= !manifold_ok &&
                              (mode_ff == pps_pkg::MODE_AUTO || in_test) &&
                              !(byp_sw_ff && !byp_expired_ff) && !sil_ff;
    end
  end

endmodule
